// *** umc_modem_lines.sv ***
// Modem handshake lines of the UART on the multifunction four-pin port.
// Functional notes
// - Status bit 5 reads as the inverse of the active-low data-set-ready pin in mode 2, and as zero in the other modes.
// - Status bit 1 is set whenever data-set-ready changed level since the last status read.
// - Control bit 0 at one drives terminal-ready low, at zero leaves it high.
// - Reset forces terminal-ready to its inactive high level.
// - In loopback mode terminal-ready is held inactive whatever control bit 0 says.
// - Status bit 6 reads as the inverse of the active-low ring-indicator pin in mode 2, and as zero in the other modes.
// - Status bit 2 is set when ring-indicator went low to high since the last status read.
// - A modem-status interrupt is raised when the ring status bit falls, if enabled.
// - Status bit 7 reads as the inverse of the active-low carrier-detect pin in mode 2, and as zero in the other modes.
// - Status bit 3 is set whenever carrier-detect changed level since the last status read.
// - Carrier-detect is only reported and never steers the serial receiver.
// - A change of the data-set-ready or carrier status bit raises an enabled interrupt.
// - The port pins carry the modem lines only in mode 2, and mode 0 holds after reset.
`timescale 1ns/10ps
`include "umc_defs.svh"
module umc_modem_lines (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`UMC_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  output logic irq,
  output logic uart_loopback,
  output umc_pkg::umc_mode_t port_mode,
  input wire logic [3:0] port_in,
  output logic [3:0] port_out,
  output logic [3:0] port_oe_n
);
  import umc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] mcr_reg;
  logic [7:0] mcr_next;
  logic [2:0] imask_reg;
  umc_mode_t mode_reg;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  logic [2:0] ist_reg;
  logic [2:0] ist_next;
  logic [2:0] pin_prev_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  wire uart_mode = (mode_reg == UMC_MODE_UART);
  // Outside UART mode the modem inputs read as idle high, so no status changes appear after the first cycle out of UART mode.
  wire dset_n = uart_mode ? port_in[0] : 1'b1;
  wire ring_n = uart_mode ? port_in[2] : 1'b1;
  wire carr_n = uart_mode ? port_in[3] : 1'b1;
  wire [2:0] pins_n = {carr_n, ring_n, dset_n};
  wire [`UMC_LINES-1:0] line_chg;
  genvar gi;
  generate
    for (gi = 0; gi < `UMC_LINES; gi++) begin : g_line
      assign line_chg[gi] = pins_n[gi] != pin_prev_reg[gi];
    end
  endgenerate
  wire dset_chg = line_chg[`UMC_IST_DSET];
  wire carr_chg = line_chg[`UMC_IST_CARR];
  // A change that leaves the ring line high is its trailing edge.
  wire ring_rise = ring_n & line_chg[`UMC_IST_RING];
  wire ring_fall_bit = ring_rise;
  wire wr_mcr = wr_stb && addr == `UMC_OFF_MCR;
  wire wr_imask = wr_stb && addr == `UMC_OFF_IMASK;
  wire wr_ist = wr_stb && addr == `UMC_OFF_ISTAT;
  wire wr_mode = wr_stb && addr == `UMC_OFF_PMODE;
  wire rd_msr = rd_stb && addr == `UMC_OFF_MSR;
  wire [7:0] msr_val = {~carr_n, ~ring_n, ~dset_n, 1'b0, flags_reg[2:0], 1'b0};
  wire [2:0] ev = {carr_chg, ring_fall_bit, dset_chg};
  wire tready_n = ~(mcr_reg[`UMC_MCR_TREADY] & ~mcr_reg[`UMC_MCR_LOOP]);

  //////////////////////////////////////////////////////////////////////////////
  // A new change seen in the read cycle survives the clear, so no event is lost.
  always_comb begin
    flags_next = rd_msr ? `UMC_FLAGS_RST : flags_reg;
    flags_next[`UMC_MSR_DSETC - 1] = flags_next[`UMC_MSR_DSETC - 1] | dset_chg;
    flags_next[`UMC_MSR_RING_TE - 1] = flags_next[`UMC_MSR_RING_TE - 1] | ring_rise;
    flags_next[`UMC_MSR_CARRC - 1] = flags_next[`UMC_MSR_CARRC - 1] | carr_chg;
    flags_next[3] = 1'b0;
  end

  // Sticky status, write one to clear; a set in the same cycle wins.
  assign ist_next = (ist_reg & ~(wr_ist ? wdata[2:0] : 3'h0)) | ev;
  assign mcr_next = wr_mcr ? wdata : mcr_reg;

  always_comb begin
    unique case (addr)
      `UMC_OFF_MCR: rdata_next = mcr_reg;
      `UMC_OFF_MSR: rdata_next = msr_val;
      `UMC_OFF_IMASK: rdata_next = {5'h00, imask_reg};
      `UMC_OFF_ISTAT: rdata_next = {5'h00, ist_reg};
      `UMC_OFF_PMODE: rdata_next = {6'h00, mode_reg};
      default: rdata_next = `UMC_ZERO8;
    endcase
    if (!rd_stb) begin
      rdata_next = `UMC_ZERO8;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcr_reg <= `UMC_MCR_RST;
    end else begin
      mcr_reg <= mcr_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      imask_reg <= `UMC_IMASK_RST;
    end else begin
      imask_reg <= wr_imask ? wdata[`UMC_IST_CARR:0] : imask_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg <= UMC_MODE_GPIO;
    end else begin
      mode_reg <= wr_mode ? umc_mode_t'(wdata[1:0]) : mode_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags_reg <= `UMC_FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ist_reg <= `UMC_IST_RST;
    end else begin
      ist_reg <= ist_next;
    end
  end

  // Reset to the idle high level, so no false change follows reset.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= `UMC_PREV_RST;
    end else begin
      pin_prev_reg <= pins_n;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `UMC_ZERO8;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carrier-detect leaves the chip only as status; the receiver has no input from it.
  assign rdata = rdata_reg;
  assign irq = |(ist_reg & imask_reg);
  assign uart_loopback = mcr_reg[`UMC_MCR_LOOP];
  assign port_mode = mode_reg;
  // Only line 1 is driven, and only in UART mode; the rest stay inputs.
  assign port_out = {2'b11, tready_n, 1'b1};
  assign port_oe_n = uart_mode ? `UMC_OE_UART : `UMC_PIN_IDLE;

  //////////////////////////////////////////////////////////////////////////////
  AST_DSET_INV: assert property (
    @(posedge clk) disable iff (rst) rd_msr |=> rdata[`UMC_MSR_DSET] == ~$past(dset_n))
    else $error("Data-set-ready status not inverse of pin.");

  AST_RING_INV: assert property (
    @(posedge clk) disable iff (rst) rd_msr |=> rdata[`UMC_MSR_RING] == ~$past(ring_n))
    else $error("Ring status not inverse of pin.");

  AST_CARR_INV: assert property (
    @(posedge clk) disable iff (rst) rd_msr |=> rdata[`UMC_MSR_CARR] == ~$past(carr_n))
    else $error("Carrier status not inverse of pin.");

  AST_DSET_CHG: assert property (
    @(posedge clk) disable iff (rst)
    uart_mode && $changed(port_in[0]) && $past(uart_mode) |=> flags_reg[0])
    else $error("Data-set-ready change not flagged.");

  AST_RING_TE: assert property (
    @(posedge clk) disable iff (rst)
    uart_mode && $rose(port_in[2]) && $past(uart_mode) |=> flags_reg[1])
    else $error("Ring trailing edge not flagged.");

  AST_CARR_CHG: assert property (
    @(posedge clk) disable iff (rst)
    uart_mode && $changed(port_in[3]) && $past(uart_mode) |=> flags_reg[2])
    else $error("Carrier change not flagged.");

  AST_DSET_HOLD: assert property (
    @(posedge clk) disable iff (rst) flags_reg[0] && !rd_msr |=> flags_reg[0])
    else $error("Data-set-ready change flag lost before a read.");

  AST_RING_HOLD: assert property (
    @(posedge clk) disable iff (rst) flags_reg[1] && !rd_msr |=> flags_reg[1])
    else $error("Ring trailing-edge flag lost before a read.");

  AST_CARR_HOLD: assert property (
    @(posedge clk) disable iff (rst) flags_reg[2] && !rd_msr |=> flags_reg[2])
    else $error("Carrier change flag lost before a read.");

  AST_TREADY: assert property (
    @(posedge clk) disable iff (rst)
    mcr_reg[`UMC_MCR_TREADY] && !uart_loopback |-> !port_out[1])
    else $error("Terminal-ready not driven active.");

  AST_TREADY_OFF: assert property (
    @(posedge clk) disable iff (rst) !mcr_reg[`UMC_MCR_TREADY] |-> port_out[1])
    else $error("Terminal-ready active with control bit clear.");

  AST_RST_TREADY: assert property (
    @(posedge clk) rst ##1 rst |-> port_out[1] && port_oe_n == `UMC_PIN_IDLE)
    else $error("Terminal-ready not inactive in reset.");

  AST_LOOP: assert property (
    @(posedge clk) disable iff (rst) wr_mcr && wdata[`UMC_MCR_LOOP] |=> port_out[1])
    else $error("Terminal-ready active in loopback.");

  AST_LOOP_HOLD: assert property (
    @(posedge clk) disable iff (rst) uart_loopback |-> port_out[1])
    else $error("Terminal-ready active while loopback is set.");

  AST_RD_CLR: assert property (
    @(posedge clk) disable iff (rst)
    rd_msr && !dset_chg && !ring_rise && !carr_chg |=> flags_reg == `UMC_FLAGS_RST)
    else $error("Status read did not clear flags.");

  AST_MSR_RSVD: assert property (
    @(posedge clk) disable iff (rst)
    rd_msr |=> !rdata[`UMC_MSR_RSVD_LO] && !rdata[`UMC_MSR_RSVD_HI])
    else $error("Unused status bits not zero.");

  AST_RDATA_IDLE: assert property (
    @(posedge clk) disable iff (rst) !rd_stb |=> rdata == `UMC_ZERO8)
    else $error("Read data not zero outside a read.");

  AST_UNMAPPED: assert property (
    @(posedge clk) disable iff (rst) rd_stb && addr > `UMC_OFF_PMODE |=> rdata == `UMC_ZERO8)
    else $error("Unmapped address read not zero.");

  AST_WR_MCR: assert property (
    @(posedge clk) disable iff (rst) wr_mcr |=> mcr_reg == $past(wdata))
    else $error("Control register write lost.");

  AST_IRQ: assert property (
    @(posedge clk) disable iff (rst) ev[1] && imask_reg[1] && !wr_imask |=> irq)
    else $error("Ring interrupt not raised.");

  AST_IRQ_CHG: assert property (
    @(posedge clk) disable iff (rst)
    (ev[0] || ev[2]) && imask_reg[0] && imask_reg[2] && !wr_imask |=> irq)
    else $error("Change interrupt not raised.");

  AST_IRQ_LOW: assert property (
    @(posedge clk) disable iff (rst) imask_reg == `UMC_IMASK_RST |-> !irq)
    else $error("Interrupt raised with all sources masked.");

  AST_IST_STICKY: assert property (
    @(posedge clk) disable iff (rst) !wr_ist |=> (ist_reg & $past(ist_reg)) == $past(ist_reg))
    else $error("Interrupt status bit lost without a clear.");

  AST_MODE: assert property (
    @(posedge clk) disable iff (rst) !uart_mode |-> port_oe_n == `UMC_PIN_IDLE)
    else $error("Port driven outside UART mode.");

  AST_OE_UART: assert property (
    @(posedge clk) disable iff (rst) uart_mode |-> port_oe_n == `UMC_OE_UART)
    else $error("Terminal-ready line not driven in UART mode.");

  AST_GPIO_QUIET: assert property (
    @(posedge clk) disable iff (rst)
    !uart_mode && !$past(uart_mode) |-> !dset_chg && !ring_rise && !carr_chg)
    else $error("Modem event seen outside UART mode.");

  COV_RING: cover property (@(posedge clk) disable iff (rst) ring_rise ##1 rd_msr);
  COV_IRQ: cover property (@(posedge clk) disable iff (rst) $rose(irq));
  COV_LOOP: cover property (@(posedge clk) disable iff (rst) mcr_reg[0] && mcr_reg[4]);
  COV_SET_CLR: cover property (@(posedge clk) disable iff (rst) rd_msr && dset_chg);
endmodule : umc_modem_lines

// *** umc_defs.svh ***
// Offsets, field positions and reset values of the modem control lines block.
`ifndef UMC_DEFS_SVH
`define UMC_DEFS_SVH
`define UMC_ADDR_W 3
`define UMC_OFF_MCR 3'h0
`define UMC_OFF_MSR 3'h1
`define UMC_OFF_IMASK 3'h2
`define UMC_OFF_ISTAT 3'h3
`define UMC_OFF_PMODE 3'h4
`define UMC_MCR_TREADY 0
`define UMC_MCR_LOOP 4
`define UMC_MSR_DSETC 1
`define UMC_MSR_RING_TE 2
`define UMC_MSR_CARRC 3
`define UMC_MSR_DSET 5
`define UMC_MSR_RING 6
`define UMC_MSR_CARR 7
`define UMC_IST_DSET 0
`define UMC_IST_RING 1
`define UMC_IST_CARR 2
`define UMC_MCR_RST 8'h00
`define UMC_IMASK_RST 3'h0
`define UMC_PMODE_RST 2'h0
`define UMC_PIN_IDLE 4'hF
`define UMC_ZERO8 8'h00
`define UMC_LINES 3
`define UMC_FLAGS_RST 4'h0
`define UMC_IST_RST 3'h0
`define UMC_PREV_RST 3'h7
`define UMC_OE_UART 4'hD
`define UMC_MSR_RSVD_LO 0
`define UMC_MSR_RSVD_HI 4
`endif

// *** umc_pkg.sv ***
// Types shared by the modem control lines block.
package umc_pkg;
  typedef enum logic [1:0] {
    UMC_MODE_GPIO = 2'b00,
    UMC_MODE_HDLC = 2'b01,
    UMC_MODE_UART = 2'b10,
    UMC_MODE_RSVD = 2'b11
  } umc_mode_t;
endpackage : umc_pkg

// *** umc_modem_model.sv ***
// Behavioural modem that drives the handshake inputs of the port.
`timescale 1ns/10ps
module umc_modem_model (
  input wire logic dsr_on,
  input wire logic ring_on,
  input wire logic carr_on,
  input wire logic term_wire,
  output logic [3:0] pins
);
  ////////////////////////////////////////////////////////////////////////
  // Ready, ringing and carrier present are shown as a low level.
  assign pins[0] = ~dsr_on;
  assign pins[1] = term_wire;
  assign pins[2] = ~ring_on;
  assign pins[3] = ~carr_on;
endmodule : umc_modem_model

// *** uart_modem_control_lines_bench.sv ***
// Self-checking bench of the modem control lines block.
`timescale 1ns/10ps
module uart_modem_control_lines_bench;
  import umc_pkg::*;
  logic clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, rd_pend = 0;
  logic dsr = 0, ring = 0, carr = 0, cw = 0, loopb, irq;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0, rdata;
  logic [3:0] pins, pout, oe_n;
  umc_mode_t mode;
  logic [7:0] q[$];
  int mismatches = 0, checked = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  umc_modem_lines uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .uart_loopback(loopb), .port_mode(mode),
    .port_in(pins), .port_out(pout), .port_oe_n(oe_n));
  // The pin is pulled high whenever the port does not drive it.
  umc_modem_model modem (.dsr_on(dsr), .ring_on(ring), .carr_on(carr),
    .term_wire(oe_n[1] ? 1'b1 : pout[1]), .pins(pins));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic results();
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge clk) wr_stb <= 1'b0;
  endtask : wr
  // The expected value is queued as the read is issued.
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    q.push_back(exp);
    @(posedge clk) {addr, rd_stb} <= {a, 1'b1};
    @(posedge clk) rd_stb <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : rd
  task automatic pin(input logic d, input logic r, input logic c);
    @(posedge clk) {dsr, ring, carr} <= {d, r, c};
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : pin
  always @(posedge clk) begin
    if (rd_pend) chk(rdata, q.pop_front());
    rd_pend <= rd_stb;
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    logic c;
    c = 1'($urandom(32'h5429e93c));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({7'h00, pout[1]}, 8'h01);
    rd(3'h4, 8'h00);
    wr(3'h4, 8'h02);
    wr(3'h2, 8'h07);
    @(negedge clk);
    chk({4'h0, oe_n}, 8'h0D);
    wr(3'h0, 8'h01);
    @(negedge clk);
    chk({7'h00, pout[1]}, 8'h00);
    wr(3'h0, 8'h11);
    @(negedge clk);
    chk({7'h00, pout[1]}, 8'h01);
    wr(3'h0, 8'h00);
    pin(1, 0, 0);
    chk({7'h00, irq}, 8'h01);
    rd(3'h1, 8'h22);
    rd(3'h1, 8'h20);
    rd(3'h3, 8'h01);
    wr(3'h3, 8'h07);
    pin(1, 1, 0);
    rd(3'h1, 8'h60);
    pin(1, 0, 0);
    rd(3'h1, 8'h24);
    rd(3'h3, 8'h02);
    for (int i = 0; i < 8; i++) begin
      c = carr;
      pin(1, 0, 1'($urandom));
      rd(3'h1, {carr, 3'h2, carr != c, 3'h0});
    end
    wr(3'h3, 8'h07);
    wr(3'h2, 8'h00);
    pin(1, 0, ~carr);
    chk({7'h00, irq}, 8'h00);
    rd(3'h3, 8'h04);
    rd(3'h5, 8'h00);
    results();
  end
endmodule : uart_modem_control_lines_bench
